// [bench/tb_dual_8bit_timer_cascade_ctrl.sv]
// self-checking testbench for the dual 8-bit timer pair over apb
`timescale 1ns/1ps

module tb_dual_8bit_timer_cascade_ctrl;
    import timer_pair_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    localparam int INST = 1;
    logic        clock   = 1'b0;
    logic        arst_n  = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        b_pin;
    logic        b_sel;
    int          fails      = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          seed       = 32'h2f5f;

    timer_pair #(.ADDR_W(12), .INST_CLKS(INST)) timer_pair_i (
        .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_pair_irq(irq),
        .timer_a_wave_pin(), .timer_a_wave_sel(),
        .timer_b_wave_pin(b_pin), .timer_b_wave_sel(b_sel));

    always #20 clock = ~clock;

    // hang guard: far above the longest expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 20000) begin
            fails++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] ctl(logic f, logic ie, logic [1:0] wv, logic [1:0] cs,
                                       logic ps, logic rn);
        return {f, ie, wv, cs, ps, rn};
    endfunction

    function automatic int div_of(int cs);
        return (cs == 0) ? 2 : (cs == 1) ? 32 : 128;
    endfunction

    function automatic logic [11:0] ba(logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_byte(string name, logic [7:0] exp, logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_range(string name, int lo, int hi, logic [15:0] got);
        num_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            fails++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic [11:0] a, input logic wr, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'($random(seed)), wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata[7:0];
        err = pslverr;
        if (pready !== 1'b1) fails++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        apb(ba(idx), 1'b1, d, r, e);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] r);
        logic e;
        apb(ba(idx), 1'b0, 8'h00, r, e);
    endtask

    // polls a control register until its match flag reads one
    task automatic wait_flag(input logic [7:0] idx, output int el);
        logic [7:0] r;
        int         t0;
        t0 = cycles;
        r  = 8'h00;
        for (int i = 0; i < 400 && r[FLAG_BIT] !== 1'b1; i++) rd(idx, r);
        el = cycles - t0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] r;
        logic [7:0] r1;
        logic [7:0] d;
        logic       e;
        int         el;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        rd(TIMER_B_CONTROL_IDX, r);
        check_byte("b_ctl reset", CONTROL_RESET, r);
        wr(TIMER_A_COMPARE_DATA_IDX, 8'h5a);
        rd(TIMER_A_COMPARE_DATA_IDX, r);
        check_byte("a_data reads count", COUNT_RESET, r);
        apb(12'h0a6, 1'b0, 8'h00, r, e);
        check_byte("misaligned err", 8'h01, {7'h00, e});
        apb(12'h3f0, 1'b1, 8'hff, r, e);
        check_byte("unmapped err", 8'h01, {7'h00, e});
        $display("test reset_map done");

        // each internal clock code: period, flag set, irq gating, clear
        for (int cs = 0; cs < 3; cs++) begin
            d = 8'($unsigned($random(seed)) % 6) + 8'h01;
            wr(TIMER_B_COMPARE_DATA_IDX, d);
            wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, 2'(cs), 1'b0, 1'b1));
            wait_flag(TIMER_B_CONTROL_IDX, el);
            check_range("b period", int'(d) * div_of(cs) * INST - 2,
                        (int'(d) + 1) * div_of(cs) * INST + 8, 16'(el));
            repeat (2) @(posedge clock);
            check_byte("irq masked", 8'h00, {7'h00, irq});
            wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b1, 2'h0, 2'(cs), 1'b0, 1'b0));
            repeat (2) @(posedge clock);
            check_byte("irq raised", 8'h01, {7'h00, irq});
            rd(TIMER_B_CONTROL_IDX, r);
            check_byte("flag kept", ctl(1'b1, 1'b1, 2'h0, 2'(cs), 1'b0, 1'b0), r);
            wr(TIMER_B_CONTROL_IDX, ctl(1'b0, 1'b1, 2'h0, 2'(cs), 1'b0, 1'b0));
            rd(TIMER_B_CONTROL_IDX, r);
            check_byte("flag cleared", ctl(1'b0, 1'b1, 2'h0, 2'(cs), 1'b0, 1'b0), r);
            check_byte("irq dropped", 8'h00, {7'h00, irq});
        end
        $display("test clock_codes done");

        // pause holds, resume continues, restart clears, late data waits
        wr(TIMER_B_COMPARE_DATA_IDX, COUNT_FULL);
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, CLKSEL_DIV2, 1'b0, 1'b1));
        repeat (30) @(posedge clock);
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, CLKSEL_DIV2, 1'b1, 1'b1));
        rd(TIMER_B_COMPARE_DATA_IDX, r1);
        repeat (40) @(posedge clock);
        rd(TIMER_B_COMPARE_DATA_IDX, r);
        check_byte("paused count", r1, r);
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, CLKSEL_DIV2, 1'b0, 1'b1));
        repeat (40) @(posedge clock);
        rd(TIMER_B_COMPARE_DATA_IDX, r);
        check_range("resumed count", int'(r1) + 15, int'(r1) + 30, {8'h00, r});
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, CLKSEL_DIV2, 1'b0, 1'b0));
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, CLKSEL_DIV2, 1'b0, 1'b1));
        rd(TIMER_B_COMPARE_DATA_IDX, r);
        check_range("restart count", 0, 3, {8'h00, r});
        wr(TIMER_B_COMPARE_DATA_IDX, 8'h02);
        repeat (30) @(posedge clock);
        rd(TIMER_B_COMPARE_DATA_IDX, r);
        check_range("late data", 8, 22, {8'h00, r});
        wr(TIMER_B_CONTROL_IDX, ctl(1'b0, 1'b0, 2'h0, CLKSEL_DIV2, 1'b0, 1'b0));
        $display("test pause_restart done");

        // preset levels shown on the pin while stopped
        for (int p = 1; p < 3; p++) begin
            wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'(p), CLKSEL_DIV2, 1'b0, 1'b0));
            wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, WAVE_ON_PIN, CLKSEL_DIV2, 1'b0, 1'b0));
            repeat (2) @(posedge clock);
            check_byte("wave sel", 8'h01, {7'h00, b_sel});
            check_byte("wave level", {7'h00, p[1]}, {7'h00, b_pin});
        end
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b0, 2'h0, CLKSEL_DIV2, 1'b0, 1'b0));
        repeat (2) @(posedge clock);
        check_byte("port mode", 8'h00, {7'h00, b_sel});
        $display("test wave done");

        // cascade: timer a controls, 16-bit compare from both data bytes
        wr(TIMER_B_COMPARE_DATA_IDX, 8'h01);
        wr(TIMER_A_COMPARE_DATA_IDX, 8'h02);
        wr(TIMER_B_CONTROL_IDX, ctl(1'b1, 1'b1, 2'h0, CLKSEL_CASCADE, 1'b1, 1'b0));
        wr(TIMER_A_CONTROL_IDX, ctl(1'b1, 1'b1, 2'h0, CLKSEL_DIV2, 1'b0, 1'b1));
        wait_flag(TIMER_A_CONTROL_IDX, el);
        check_range("cascade period", 258 * 2 * INST - 2, 259 * 2 * INST + 8,
                    16'(el));
        rd(TIMER_B_CONTROL_IDX, r);
        check_byte("b flag inert", 8'h4e, r);
        wr(TIMER_A_CONTROL_IDX, ctl(1'b0, 1'b1, 2'h0, CLKSEL_DIV2, 1'b0, 1'b0));
        repeat (2) @(posedge clock);
        check_byte("cascade irq off", 8'h00, {7'h00, irq});
        $display("test cascade done");
        close_out();
    end

endmodule

// [core/timer_pair.sv]
// dual 8-bit interval timer with 16-bit cascade, apb register slave
`timescale 1ns/1ps

module timer_pair
    import timer_pair_pkg::*;
#(
    parameter int ADDR_W    = 12,
    parameter int INST_CLKS = INST_CLKS_DEFAULT
) (
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   timer_pair_irq,
    output logic                   timer_a_wave_pin,
    output logic                   timer_a_wave_sel,
    output logic                   timer_b_wave_pin,
    output logic                   timer_b_wave_sel
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [1:0] flag_q;
    logic [1:0] ie_q;
    logic [1:0] os_q [2];
    logic [1:0] cs_q [2];
    logic [1:0] stp_q;
    logic [1:0] str_q;
    logic [7:0] data_q  [2];
    logic [7:0] latch_q [2];
    logic [7:0] cnt_q   [2];
    logic [1:0] init_q;
    logic [1:0] wave_q;
    logic [1:0] sel_q;
    logic       irq_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [$clog2(INST_CLKS+1)-1:0] inst_cnt_q;
    logic [PRESCALE_W-1:0]          pre_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: one wait-free access phase after every setup
    wire [ADDR_W-3:0] word_idx = paddr[ADDR_W-1:2];
    wire        lane_ok  = (paddr[1:0] == 2'h0);
    wire        sel_bc   = lane_ok && (word_idx == (ADDR_W-2)'(TIMER_B_CONTROL_IDX));
    wire        sel_ac   = lane_ok && (word_idx == (ADDR_W-2)'(TIMER_A_CONTROL_IDX));
    wire        sel_bd   = lane_ok && (word_idx == (ADDR_W-2)'(TIMER_B_COMPARE_DATA_IDX));
    wire        sel_ad   = lane_ok && (word_idx == (ADDR_W-2)'(TIMER_A_COMPARE_DATA_IDX));
    wire        addr_ok  = sel_bc || sel_ac || sel_bd || sel_ad;
    wire        setup    = psel && !penable;
    wire        apb_wr   = psel && penable && pready_q && pwrite && addr_ok;
    wire [1:0]  wr_ctl   = {apb_wr && sel_bc, apb_wr && sel_ac};
    wire [1:0]  wr_dat   = {apb_wr && sel_bd, apb_wr && sel_ad};
    wire [7:0]  ctl_rd_a = {flag_q[0], ie_q[0], os_q[0], cs_q[0], stp_q[0], str_q[0]};
    wire [7:0]  ctl_rd_b = {flag_q[1], ie_q[1], os_q[1], cs_q[1], stp_q[1], str_q[1]};
    wire [7:0]  rd_byte  = sel_bc ? ctl_rd_b :
                           sel_ac ? ctl_rd_a :
                           sel_bd ? cnt_q[1] :
                           sel_ad ? cnt_q[0] : 8'h00;
    wire [1:0]  wave_wr  = pwdata[WAVE_HI_BIT:WAVE_LO_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // instruction cycle and count clock prescaler
    wire inst_tick = (inst_cnt_q == ($clog2(INST_CLKS+1))'(INST_CLKS - 1));
    wire tick2     = inst_tick && ((pre_q & TAP_DIV2) == TAP_DIV2);
    wire tick32    = inst_tick && ((pre_q & TAP_DIV32) == TAP_DIV32);
    wire tick128   = inst_tick && ((pre_q & TAP_DIV128) == TAP_DIV128);

    // cascade code lives in timer b clock select only
    wire cascade = (cs_q[1] == CLKSEL_CASCADE);

    ////////////////////////////////////////////////////////////////////////////
    // per-timer control signals
    logic [1:0] start_own;
    logic [1:0] stop_own;
    logic [1:0] start_e;
    logic [1:0] stop_e;
    logic [1:0] run_e;
    logic [1:0] pause_e;
    logic [1:0] base_tick;
    logic [1:0] tick_e;
    logic [1:0] match8;
    logic [1:0] hit;
    logic [1:0] fset;
    logic [1:0] fclr;

    wire match16 = match8[0] && match8[1];

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_timer
            // in cascade timer b follows timer a controls
            localparam bit FOLLOW = (i == 1);

            assign start_own[i] = wr_ctl[i] && pwdata[RUN_BIT] && !str_q[i];
            assign stop_own[i]  = wr_ctl[i] && !pwdata[RUN_BIT];
            assign start_e[i]   = (FOLLOW && cascade) ? start_own[0] : start_own[i];
            assign stop_e[i]    = (FOLLOW && cascade) ? stop_own[0] : stop_own[i];
            assign run_e[i]     = (FOLLOW && cascade) ? str_q[0] : str_q[i];
            assign pause_e[i]   = (FOLLOW && cascade) ? stp_q[0] : stp_q[i];

            // timer a code 11 is the external clock, which is not wired here
            assign base_tick[i] = (cs_q[i] == CLKSEL_DIV2)   ? tick2 :
                                  (cs_q[i] == CLKSEL_DIV32)  ? tick32 :
                                  (cs_q[i] == CLKSEL_DIV128) ? tick128 : 1'b0;

            if (i == 0) begin : g_low
                assign tick_e[0] = base_tick[0] && run_e[0] && !pause_e[0];
                assign hit[0]    = tick_e[0] && (cascade ? match16 : match8[0]);
            end else begin : g_high
                // carry out of the low byte steps the high byte
                assign tick_e[1] = cascade ? (tick_e[0] && cnt_q[0] == COUNT_FULL)
                                           : (base_tick[1] && run_e[1] && !pause_e[1]);
                assign hit[1]    = cascade ? hit[0] : (tick_e[1] && match8[1]);
            end

            assign match8[i] = (cnt_q[i] == latch_q[i]);
            // a stop write in the same cycle swallows the match flag
            assign fset[i] = hit[i] && !stop_e[i] && !(FOLLOW && cascade);
            assign fclr[i] = wr_ctl[i] && !pwdata[FLAG_BIT];

            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    ie_q[i]  <= CONTROL_RESET[IRQ_EN_BIT];
                    os_q[i]  <= CONTROL_RESET[WAVE_HI_BIT:WAVE_LO_BIT];
                    cs_q[i]  <= CONTROL_RESET[CLKSEL_HI_BIT:CLKSEL_LO_BIT];
                    stp_q[i] <= CONTROL_RESET[PAUSE_BIT];
                    str_q[i] <= CONTROL_RESET[RUN_BIT];
                end else if (wr_ctl[i]) begin
                    ie_q[i]  <= pwdata[IRQ_EN_BIT];
                    os_q[i]  <= wave_wr;
                    cs_q[i]  <= pwdata[CLKSEL_HI_BIT:CLKSEL_LO_BIT];
                    stp_q[i] <= pwdata[PAUSE_BIT];
                    str_q[i] <= pwdata[RUN_BIT];
                end
            end

            // hardware set wins over a software clear in the same cycle
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    flag_q[i] <= CONTROL_RESET[FLAG_BIT];
                end else if (fset[i]) begin
                    flag_q[i] <= 1'b1;
                end else if (fclr[i]) begin
                    flag_q[i] <= 1'b0;
                end
            end

            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    data_q[i] <= DATA_RESET;
                end else if (wr_dat[i]) begin
                    data_q[i] <= pwdata[7:0];
                end
            end

            // latch only moves at start or match, so a running write waits
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    latch_q[i] <= DATA_RESET;
                end else if (start_e[i] || hit[i]) begin
                    latch_q[i] <= data_q[i];
                end
            end

            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    cnt_q[i] <= COUNT_RESET;
                end else if (start_e[i] || hit[i]) begin
                    cnt_q[i] <= COUNT_RESET;
                end else if (tick_e[i]) begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end
            end

            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    init_q[i] <= 1'b0;
                end else if (wr_ctl[i] && wave_wr == WAVE_PRESET_LOW) begin
                    init_q[i] <= 1'b0;
                end else if (wr_ctl[i] && wave_wr == WAVE_PRESET_HIGH) begin
                    init_q[i] <= 1'b1;
                end
            end

            // stopped timer parks the wave at the preset, each match toggles it
            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    wave_q[i] <= 1'b0;
                    sel_q[i]  <= 1'b0;
                end else begin
                    wave_q[i] <= !run_e[i] ? init_q[i] : (hit[i] ? !wave_q[i] : wave_q[i]);
                    sel_q[i]  <= (os_q[i] == WAVE_ON_PIN);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // prescaler, interrupt and bus answer flops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            inst_cnt_q <= '0;
            pre_q      <= '0;
        end else begin
            inst_cnt_q <= inst_tick ? '0 : inst_cnt_q + 1'b1;
            pre_q      <= inst_tick ? pre_q + 1'b1 : pre_q;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (flag_q[0] && ie_q[0]) || (flag_q[1] && ie_q[1] && !cascade);
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_ok;
            prdata_q  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign timer_pair_irq   = irq_q;
    assign timer_a_wave_pin = wave_q[0];
    assign timer_a_wave_sel = sel_q[0];
    assign timer_b_wave_pin = wave_q[1];
    assign timer_b_wave_sel = sel_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    flag_set_a: assert property (fset[1] |=> flag_q[1] && !$past(cascade))
        else $error("timer b flag not set on match");
    irq_drive_a: assert property (flag_q[1] && ie_q[1] && !cascade |=> timer_pair_irq)
        else $error("irq missing with flag and enable");
    flag_clear_a: assert property (fclr[1] && !fset[1] |=> !flag_q[1])
        else $error("zero write did not clear flag");
    flag_keep_a: assert property (wr_ctl[1] && pwdata[FLAG_BIT] && flag_q[1] |=> flag_q[1])
        else $error("one write changed flag");
    cascade_inert_a: assert property (cascade && !wr_ctl[1] |=> flag_q[1] == $past(flag_q[1]))
        else $error("timer b flag moved in cascade");
    pin_select_a: assert property (##1 timer_b_wave_sel == ($past(os_q[1]) == WAVE_ON_PIN))
        else $error("pin select disagrees with wave field");
    preset_low_a: assert property (wr_ctl[1] && wave_wr == WAVE_PRESET_LOW |=> !init_q[1])
        else $error("preset low not taken");
    // the pin flop copies the preset one clock late, so compare against last cycle's preset
    idle_level_a: assert property (!run_e[1] ##1 !run_e[1] |=> timer_b_wave_pin == $past(init_q[1]))
        else $error("stopped pin not at preset");
    preset_high_a: assert property (wr_ctl[1] && wave_wr == WAVE_PRESET_HIGH |=> init_q[1])
        else $error("preset high not taken");
    a_flag_set_a: assert property (fset[0] |=> flag_q[0])
        else $error("timer a flag not set on match");
    irq_quiet_a: assert property (!flag_q[0] && !(flag_q[1] && ie_q[1] && !cascade) |=> !timer_pair_irq)
        else $error("irq without flag and enable");
    stop_hold_a: assert property (!run_e[0] && !start_e[0] |=> cnt_q[0] == $past(cnt_q[0]))
        else $error("stopped counter moved");
    late_data_a: assert property (!start_e[0] && !hit[0] |=> latch_q[0] == $past(latch_q[0]))
        else $error("latch moved without start or match");
    high_start_a: assert property (cascade && start_own[0] |=> cnt_q[1] == COUNT_RESET && latch_q[1] == $past(data_q[1]))
        else $error("high byte not started by timer a");
    low_reload_a: assert property (cascade && hit[0] |=> latch_q[0] == $past(data_q[0]))
        else $error("low byte not reloaded on match");
    pause_hold_a: assert property (pause_e[0] && !start_e[0] |=> cnt_q[0] == $past(cnt_q[0]))
        else $error("counter moved while paused");
    start_load_a: assert property (start_e[0] |=> cnt_q[0] == COUNT_RESET && latch_q[0] == $past(data_q[0]))
        else $error("start did not clear and load");
    match_reload_a: assert property (hit[1] && !start_e[1] |=> cnt_q[1] == COUNT_RESET && latch_q[1] == $past(data_q[1]))
        else $error("match did not reload");
    count_step_a: assert property (tick_e[1] && !hit[1] && !start_e[1] |=> cnt_q[1] == $past(cnt_q[1]) + 8'h01)
        else $error("counter did not step");
    carry_step_a: assert property (cascade && tick_e[0] && cnt_q[0] == COUNT_FULL && !hit[0] && !start_e[0] |=> cnt_q[1] == $past(cnt_q[1]) + 8'h01)
        else $error("high byte missed carry");
    stop_noflag_a: assert property (stop_e[0] && !flag_q[0] |=> !flag_q[0])
        else $error("flag set on stopping match");
    read_count_a: assert property (setup && !pwrite && sel_ad |=> prdata[7:0] == $past(cnt_q[0]))
        else $error("data read not live count");
    mode_select_a: assert property (!cascade && cs_q[1] == CLKSEL_DIV32 && run_e[1] && !pause_e[1] |-> tick_e[1] == tick32)
        else $error("count clock select wrong");

    match8_c: cover property (fset[1] && !cascade);
    match16_c: cover property (cascade && fset[0] && latch_q[1] != 8'h00);
    resume_c: cover property (pause_e[0] && run_e[0] ##1 !pause_e[0] ##[1:300] tick_e[0]);
    cascade_start_c: cover property (cascade && start_e[0]);

endmodule

// [core/timer_pair_pkg.sv]
// constants shared by the dual 8-bit timer with cascade option
package timer_pair_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address of each is four times its index
    localparam logic [7:0] TIMER_B_CONTROL_IDX      = 8'h26;
    localparam logic [7:0] TIMER_A_CONTROL_IDX      = 8'h27;
    localparam logic [7:0] TIMER_B_COMPARE_DATA_IDX = 8'h28;
    localparam logic [7:0] TIMER_A_COMPARE_DATA_IDX = 8'h29;

    ////////////////////////////////////////////////////////////////////////////
    // control register field positions, same layout for both timers
    localparam int FLAG_BIT     = 7;
    localparam int IRQ_EN_BIT   = 6;
    localparam int WAVE_HI_BIT  = 5;
    localparam int WAVE_LO_BIT  = 4;
    localparam int CLKSEL_HI_BIT = 3;
    localparam int CLKSEL_LO_BIT = 2;
    localparam int PAUSE_BIT    = 1;
    localparam int RUN_BIT      = 0;

    ////////////////////////////////////////////////////////////////////////////
    // field codes
    localparam logic [1:0] CLKSEL_DIV2    = 2'h0;
    localparam logic [1:0] CLKSEL_DIV32   = 2'h1;
    localparam logic [1:0] CLKSEL_DIV128  = 2'h2;
    localparam logic [1:0] CLKSEL_CASCADE = 2'h3;
    localparam logic [1:0] WAVE_PRESET_LOW  = 2'h1;
    localparam logic [1:0] WAVE_PRESET_HIGH = 2'h2;
    localparam logic [1:0] WAVE_ON_PIN      = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and prescaler taps
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] COUNT_FULL    = 8'hff;
    localparam int         PRESCALE_W    = 7;
    localparam logic [6:0] TAP_DIV2      = 7'h01;
    localparam logic [6:0] TAP_DIV32     = 7'h1f;
    localparam logic [6:0] TAP_DIV128    = 7'h7f;
    localparam int         INST_CLKS_DEFAULT = 4;

endpackage
